// >>> dv/eocb_cmd_assertions.sv
// Port-level checker for the option command interpreter
`timescale 1ns/1ns
module eocb_cmd_assertions
#(
   parameter OP_CYCLES = 1000
)
(
   // Clock and reset
   input wire       mclk,
   input wire       rst_n,
   // Watched ports
   input wire       csel_n_pin,
   input wire       sdout_oe_r,
   input wire       busy_r,
   input wire [7:0] common_electrode_voltage_r,
   input wire       common_electrode_voltage_code_valid_r,
   input wire       internal_clock_on_r,
   input wire       analog_supply_on_r,
   input wire [1:0] border_sel_r,
   input wire       lut_wr_r,
   input wire [7:0] lut_addr_r,
   input wire [4:0] otp_op_r
);
   reg [15:0] busy_cnt_r;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Length of the current busy stretch
   always @(posedge mclk or negedge rst_n)
      if (!rst_n)
         busy_cnt_r <= 16'h0;
      else
         busy_cnt_r <= busy_r ? busy_cnt_r + 16'h1 : 16'h0;
   a_common_electrode_voltage_valid_code: assert property (
      $stable(common_electrode_voltage_r) |-> common_electrode_voltage_code_valid_r ==
      (common_electrode_voltage_r >= 8'h08 && common_electrode_voltage_r <= 8'h78
       && common_electrode_voltage_r[1:0] == 2'h0)) else $error("common_electrode_voltage valid flag wrong");
   a_busy_op_onehot: assert property (
      busy_r && $past(busy_r) |-> $onehot(otp_op_r[3:0])) else $error("op code not one-hot");
   a_op_spare_bit: assert property (
      otp_op_r[4] == 1'b0) else $error("unused op bit set");
   a_busy_full_length: assert property (
      $fell(busy_r) |-> busy_cnt_r == OP_CYCLES) else $error("busy length wrong");
   a_busy_no_overrun: assert property (
      busy_r |-> busy_cnt_r < OP_CYCLES) else $error("busy too long");
   a_lut_single_pulse: assert property (
      lut_wr_r |-> (lut_addr_r <= 8'd152) ##1 !lut_wr_r) else $error("lut write pulse bad");
   a_cfg_busy_frozen: assert property (
      busy_r && $past(busy_r) |-> $stable(common_electrode_voltage_r) && $stable(border_sel_r))
      else $error("config changed while busy");
   a_analog_needs_clk: assert property (
      analog_supply_on_r |-> internal_clock_on_r) else $error("analog on without clock");
   a_oe_release: assert property (
      csel_n_pin [*6] |-> !sdout_oe_r) else $error("read driver left on");
endmodule // eocb_cmd_assertions
bind eocb_cmd eocb_cmd_assertions #(.OP_CYCLES(OP_CYCLES)) u_chk (.mclk, .rst_n, .csel_n_pin,
   .sdout_oe_r, .busy_r, .common_electrode_voltage_r, .common_electrode_voltage_code_valid_r, .internal_clock_on_r,
   .analog_supply_on_r, .border_sel_r, .lut_wr_r, .lut_addr_r, .otp_op_r);

// >>> dv/eocb_host.sv
// Host controller model driving the serial command port
`timescale 1ns/1ns
module eocb_host
(
   // Clock
   input  wire mclk,
   // Serial port
   output reg  sclk_pin,
   output reg  sdin_pin,
   output reg  csel_n_pin,
   output reg  dcsel_pin,
   input  wire sdout_r,
   input  wire sdout_oe_r,
   input  wire busy_r
);
   // Idle port: clock parked low, device deselected
   initial
   begin
      sclk_pin = 1'b0;
      sdin_pin = 1'b0;
      csel_n_pin = 1'b1;
      dcsel_pin = 1'b0;
   end
   // Half a serial clock period, launched just after an mclk edge
   task half;
      begin
         repeat (4) @(posedge mclk);
         #1;
      end
   endtask
   // One byte out MSB first, read bit taken at each rising edge
   task xfer(input reg dc, input reg [7:0] wv, output reg [7:0] rv);
      integer i;
      begin
         dcsel_pin = dc;
         for (i = 7; i >= 0; i = i - 1)
         begin
            sdin_pin = wv[i];
            half;
            sclk_pin = 1'b1;
            rv[i] = sdout_oe_r ? sdout_r : ~sdout_r; // Undriven line reads as garbage
            half;
            sclk_pin = 1'b0;
         end
         sdin_pin = ~sdin_pin; // Data no longer valid
      end
   endtask
   // Open a frame with a command byte once the device is idle
   task cmd(input reg [7:0] c);
      reg [7:0] d;
      begin
         wait (busy_r === 1'b0);
         half;
         csel_n_pin = 1'b0;
         xfer(1'b0, c, d);
      end
   endtask
   // Close the frame
   task stop;
      begin
         half;
         csel_n_pin = 1'b1;
         half;
      end
   endtask
endmodule // eocb_host

// >>> dv/tb.sv
// Self-checking bench for the option command interpreter
`timescale 1ns/1ns
module tb;
   localparam [1:0] ID = 2'h2; // Arbitrary identification value
   reg         mclk;
   reg         rst_n = 1'b0;
   reg         high_voltage_ok = 1'b0;
   reg         supply_low = 1'b1;
   reg  [15:0] crc_value = 16'h0;
   wire        sclk_pin, sdin_pin, csel_n_pin, dcsel_pin, sdout_r, sdout_oe_r, busy_r;
   wire        common_electrode_voltage_code_valid_r, spare_common_electrode_voltage_sel_r, ram_alternation_r, border_follow_r;
   wire        internal_clock_on_r, analog_supply_on_r, lut_wr_r;
   wire [1:0]  prog_mode_r, border_sel_r, border_level_r, border_lut_r;
   wire [7:0]  common_electrode_voltage_r, lut_addr_r, lut_data_r;
   wire [35:0] waveform_setting_bits_r;
   wire [31:0] module_version_r;
   wire [4:0]  otp_op_r;
   reg  [7:0]  pb [0:159];
   reg  [7:0]  rb [0:159];
   reg  [7:0]  code;
   integer     err_total = 0, num_checks = 0, cyc = 0, lcnt = 0, i, k;
   eocb_cmd #(.OP_CYCLES(20), .CHIP_ID(ID)) DUT (.mclk, .rst_n, .sclk_pin, .sdin_pin,
      .csel_n_pin, .dcsel_pin, .sdout_r, .sdout_oe_r, .busy_r, .high_voltage_ok, .supply_low,
      .common_electrode_voltage_r, .common_electrode_voltage_code_valid_r, .spare_common_electrode_voltage_sel_r, .waveform_setting_bits_r,
      .ram_alternation_r, .module_version_r, .prog_mode_r, .border_sel_r, .border_level_r,
      .border_follow_r, .border_lut_r, .internal_clock_on_r, .analog_supply_on_r, .lut_wr_r,
      .lut_addr_r, .lut_data_r, .otp_op_r, .crc_value);
   eocb_host host (.mclk, .sclk_pin, .sdin_pin, .csel_n_pin, .dcsel_pin, .sdout_r, .sdout_oe_r,
      .busy_r);
   // Clock source
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Compare and count
   task chk(input [63:0] seen, input [63:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp)
         begin
            err_total = err_total + 1;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // Command with n parameter or read bytes
   task op(input [7:0] c, input integer n);
      integer j;
      begin
         host.cmd(c);
         for (j = 0; j < n; j = j + 1)
            host.xfer(1'b1, pb[j], rb[j]);
         host.stop;
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // Table write monitor and hang guard, sampled mid-cycle where outputs are settled
   always @(negedge mclk)
   begin
      cyc = cyc + 1;
      if (lut_wr_r === 1'b1)
      begin
         chk({lut_addr_r, lut_data_r}, {lcnt[7:0], pb[lcnt]});
         lcnt = lcnt + 1;
      end
      if (cyc == 40000)
      begin
         err_total = err_total + 1;
         final_report;
      end
   end
   // Test sequence
   initial
   begin
      for (i = 0; i < 160; i = i + 1)
         pb[i] = (i * 7) ^ 8'h5a;
      repeat (5) @(posedge mclk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge mclk);
      chk({border_sel_r, common_electrode_voltage_r, ram_alternation_r, prog_mode_r, busy_r},
         {2'h3, 8'h00, 1'b0, 2'h0, 1'b0});
      op(8'h2f, 1);
      chk(rb[0], {6'h00, ID});
      pb[0] = 8'h80;
      op(8'h22, 1);
      chk({internal_clock_on_r, analog_supply_on_r}, 2'b10);
      pb[0] = 8'hc0;
      op(8'h22, 1);
      chk({internal_clock_on_r, analog_supply_on_r}, 2'b11);
      pb[0] = 8'h00;
      op(8'h14, 1);
      op(8'h15, 1);
      op(8'h2f, 1);
      chk(rb[0], {6'h0c, ID});
      $display("test status done");
      for (k = 0; k < 5; k = k + 1)
      begin
         code = (k == 0) ? 8'h08 : (k == 1) ? 8'h78 : (k == 2) ? 8'h0a : (k == 3) ? 8'h7c : 8'h40;
         pb[0] = code;
         op(8'h2c, 1);
         chk({common_electrode_voltage_r, common_electrode_voltage_code_valid_r},
            {code, code >= 8'h08 && code <= 8'h78 && code[1:0] == 2'h0});
      end
      $display("test common_electrode_voltage done");
      for (i = 0; i < 10; i = i + 1)
         pb[i] = 8'h97 + i * 8'h23;
      pb[0] = 8'h80;
      pb[5] = 8'h4a;
      op(8'h37, 10);
      chk({spare_common_electrode_voltage_sel_r, ram_alternation_r}, {pb[0][7], pb[5][6]});
      chk(waveform_setting_bits_r, {pb[5][3:0], pb[4], pb[3], pb[2], pb[1]});
      chk(module_version_r, {pb[6], pb[7], pb[8], pb[9]});
      op(8'h2d, 11);
      for (i = 0; i < 11; i = i + 1)
         chk(rb[i], (i == 0) ? pb[0] : (i == 1) ? 8'h40 : pb[i - 1]);
      for (i = 0; i < 10; i = i + 1)
         pb[i] = 8'h3c + i * 8'h29;
      op(8'h38, 10);
      op(8'h2e, 10);
      for (i = 0; i < 10; i = i + 1)
         chk(rb[i], pb[i]);
      $display("test option and id done");
      for (k = 0; k < 4; k = k + 1)
      begin
         code = (k == 0) ? 8'h07 : (k == 1) ? 8'h62 : (k == 2) ? 8'h81 : 8'hf6;
         pb[0] = code;
         op(8'h3c, 1);
         chk({border_sel_r, border_level_r, border_follow_r, border_lut_r},
            {code[7:4], code[2:0]});
      end
      pb[0] = 8'h03;
      op(8'h39, 1);
      chk(prog_mode_r, 2'h3);
      pb[0] = 8'h00;
      op(8'h39, 1);
      chk(prog_mode_r, 2'h0);
      $display("test border and mode done");
      op(8'h24, 1);
      crc_value = 16'hb3e1;
      for (k = 0; k < 4; k = k + 1)
      begin
         code = (k == 0) ? 8'h30 : (k == 1) ? 8'h31 : (k == 2) ? 8'h36 : 8'h34;
         op(code, 0);
         chk({busy_r, otp_op_r}, {1'b1, 5'h01 << k});
      end
      op(8'h35, 2);
      chk({rb[0], rb[1]}, 16'hb3e1);
      $display("test otp and crc done");
      for (i = 0; i < 160; i = i + 1)
         pb[i] = (i * 7) ^ 8'h5a;
      op(8'h32, 154);
      chk(lcnt, 153);
      $display("test table done");
      // Reset in mid-run brings settings and flags back to their reset values
      rst_n = 1'b0;
      repeat (2) @(posedge mclk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge mclk);
      chk({border_sel_r, common_electrode_voltage_r, ram_alternation_r, prog_mode_r, busy_r},
         {2'h3, 8'h00, 1'b0, 2'h0, 1'b0});
      chk(waveform_setting_bits_r, 36'h0);
      op(8'h2f, 1);
      chk(rb[0], {6'h00, ID});
      $display("test reset done");
      final_report;
   end
endmodule // tb

// >>> logic/eocb_cmd.v
// Option, user-ID, OTP, LUT, CRC and border command interpreter behind the serial host port
//
// Behaviour
// - 2C stores one-byte COMMON_ELECTRODE_VOLTAGE code, reset zero
// - 2D returns option, COMMON_ELECTRODE_VOLTAGE, modes, versions
// - 38 stores ten ID bytes; 2E returns them
// - Status byte: HV, SUPPLY_INPUT_LEVEL, busy, ID code
// - HV/SUPPLY_INPUT_LEVEL flags invalid until detections run
// - Busy high throughout OTP and CRC operations
// - 31 loads waveform OTP into LUT
// - 32 takes 153 LUT bytes
// - 34 starts CRC; 35 returns it MSB first
// - 36 programs option and ID into OTP
// - 37 takes ten bytes; A7 spare COMMON_ELECTRODE_VOLTAGE
// - Bytes B-E, F3:0 hold 36 mode bits
// - F6 enables ping-pong only in mode 2; the code sets ram_alternation_r from F6 in every mode
// - Bytes G-J hold ID/version, all storable
// - 39 sets program mode: 00 normal, 11 internal
// - Fixed border level from bits 5:4
// - Transition: bit2 red handling, bits1:0 LUT
// - Sequence control sets clock and analog enables
// - Detection results reported in status byte
`timescale 1ns/1ns
`include "eocb_map.vh"
module eocb_cmd
#(
   parameter OP_CYCLES = `EOCB_OP_CYCLES,
   parameter [1:0] CHIP_ID = 2'h2          // Arbitrary identification value
)
(
   // Clock and reset
   input  wire        mclk,
   input  wire        rst_n,
   // Serial host port pins
   input  wire        sclk_pin,
   input  wire        sdin_pin,
   input  wire        csel_n_pin,
   input  wire        dcsel_pin,
   output reg         sdout_r,
   output reg         sdout_oe_r,
   output reg         busy_r,
   // Analog status inputs
   input  wire        high_voltage_ok,
   input  wire        supply_low,
   // Configuration outputs
   output reg  [7:0]  common_electrode_voltage_r,
   output reg         common_electrode_voltage_code_valid_r,
   output reg         spare_common_electrode_voltage_sel_r,
   output reg  [35:0] waveform_setting_bits_r,
   output reg         ram_alternation_r,
   output reg  [31:0] module_version_r,
   output reg  [1:0]  prog_mode_r,
   output reg  [1:0]  border_sel_r,
   output reg  [1:0]  border_level_r,
   output reg         border_follow_r,
   output reg  [1:0]  border_lut_r,
   output reg         internal_clock_on_r,
   output reg         analog_supply_on_r,
   // OTP and LUT side
   output reg         lut_wr_r,
   output reg  [7:0]  lut_addr_r,
   output reg  [7:0]  lut_data_r,
   output reg  [4:0]  otp_op_r,            // 0 ws prog,1 ws load,2 sel prog,3 crc,4 unused
   input  wire [15:0] crc_value
);
   // State codes
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_PARM = 4'h2;
   localparam [3:0] ST_READ = 4'h4;
   localparam [3:0] ST_BUSY = 4'h8;

   // Border reset byte, sliced into its fields at reset
   localparam [7:0] BORDER_RST = `EOCB_BORDER_RST;

   // Synchronisers for pins and status
   reg [1:0] sclk_s, sdin_s, cs_s, dc_s, hv_s, vci_s;
   reg       sclk_d;
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_s <= 2'h0; sdin_s <= 2'h0; cs_s <= 2'h3;
         dc_s <= 2'h0; hv_s <= 2'h0; vci_s <= 2'h0; sclk_d <= 1'b0;
      end
      else
      begin
         sclk_s <= {sclk_s[0], sclk_pin};
         sdin_s <= {sdin_s[0], sdin_pin};
         cs_s   <= {cs_s[0], csel_n_pin};
         dc_s   <= {dc_s[0], dcsel_pin};
         hv_s   <= {hv_s[0], high_voltage_ok};
         vci_s  <= {vci_s[0], supply_low};
         sclk_d <= sclk_s[1];
      end
   end
   wire rise = sclk_s[1] & ~sclk_d;
   wire fall = ~sclk_s[1] & sclk_d;
   wire sel  = ~cs_s[1];

   // Option registers, user ID store and transfer state
   reg [7:0]  uid_mem [0:9];
   reg [7:0]  opt_mem [0:9];
   reg [3:0]  state_r;
   reg [7:0]  cmd_r, shift_r, tx_r;
   reg [2:0]  bit_r;
   reg [7:0]  idx_r;
   reg [15:0] crc_r;
   reg [31:0] tmr_r;
   reg        hv_valid_r, vci_valid_r, hv_flag_r, vci_flag_r;
   wire [7:0] byte_in = {shift_r[6:0], sdin_s[1]};
   wire       byte_done = rise & sel & (bit_r == 3'h7);
   wire [7:0] status_byte = {2'h0, hv_flag_r, vci_flag_r, 1'b0, busy_r, CHIP_ID};

   // Next byte to return for read commands
   reg [7:0] rd_byte;
   always @*
   begin
      rd_byte = 8'h00;
      case (cmd_r)
         `EOCB_CMD_OPT_RD:
            if (idx_r == 8'h00) rd_byte = {spare_common_electrode_voltage_sel_r, 7'h00};
            else if (idx_r == 8'h01) rd_byte = common_electrode_voltage_r;
            else if (idx_r < 8'h0b) rd_byte = opt_mem[idx_r[3:0] - 4'h2];
         `EOCB_CMD_UID_RD:   if (idx_r < 8'h0a) rd_byte = uid_mem[idx_r[3:0]];
         `EOCB_CMD_STATUS_RD: rd_byte = status_byte;
         `EOCB_CMD_CRC_RD:   rd_byte = (idx_r == 8'h00) ? crc_r[15:8] : crc_r[7:0];
         default:            rd_byte = 8'h00;
      endcase
   end

   // Option bytes B..J (stored at 0..8) map onto registered mode and version outputs
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         waveform_setting_bits_r <= 36'h0;
         module_version_r <= 32'h0;
      end
      else
      begin
         waveform_setting_bits_r <= {opt_mem[4][3:0], opt_mem[3], opt_mem[2],
                                     opt_mem[1], opt_mem[0]};
         module_version_r <= {opt_mem[5], opt_mem[6], opt_mem[7], opt_mem[8]};
      end
   end

   // Command decoder and sequencer
   integer i;
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE; cmd_r <= 8'h00; shift_r <= 8'h00; tx_r <= 8'h00;
         bit_r <= 3'h0; idx_r <= 8'h00; crc_r <= 16'h0000; tmr_r <= 32'h0;
         sdout_r <= 1'b0; sdout_oe_r <= 1'b0; busy_r <= 1'b0;
         hv_valid_r <= 1'b0; vci_valid_r <= 1'b0; hv_flag_r <= 1'b0; vci_flag_r <= 1'b0;
         common_electrode_voltage_r <= `EOCB_COMMON_ELECTRODE_VOLTAGE_RST; common_electrode_voltage_code_valid_r <= 1'b0;
         spare_common_electrode_voltage_sel_r <= 1'b0; ram_alternation_r <= 1'b0; prog_mode_r <= `EOCB_MODE_RST;
         border_sel_r <= BORDER_RST[7:6]; border_level_r <= BORDER_RST[5:4];
         border_follow_r <= BORDER_RST[2]; border_lut_r <= BORDER_RST[1:0];
         internal_clock_on_r <= 1'b0; analog_supply_on_r <= 1'b0;
         lut_wr_r <= 1'b0; lut_addr_r <= 8'h00; lut_data_r <= 8'h00; otp_op_r <= 5'h00;
         for (i = 0; i < 10; i = i + 1)
         begin
            uid_mem[i] <= 8'h00;
            opt_mem[i] <= 8'h00;
         end
      end
      else
      begin
         lut_wr_r <= 1'b0;
         // Flags are valid only after their detection has been run
         hv_flag_r  <= hv_valid_r & ~hv_s[1];
         vci_flag_r <= vci_valid_r & vci_s[1];
         // Deselect ends a read, so no stale byte is driven during the next command
         if (!sel)
         begin
            bit_r <= 3'h0;
            sdout_oe_r <= 1'b0;
            tx_r <= 8'h00;
            if (state_r == ST_READ) state_r <= ST_IDLE;
         end
         else if (rise)
         begin
            shift_r <= byte_in;
            bit_r <= bit_r + 3'h1;
         end
         // Read data shifts out MSB first on falling edges
         if (sel && fall && state_r == ST_READ)
         begin
            sdout_r <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
            sdout_oe_r <= 1'b1;
         end
         case (state_r)
            ST_IDLE, ST_PARM, ST_READ:
               if (byte_done && !dc_s[1])
               begin
                  cmd_r <= byte_in;
                  idx_r <= 8'h00;
                  state_r <= ST_PARM;
                  case (byte_in)
                     `EOCB_CMD_HV_DET:  hv_valid_r <= 1'b1;
                     `EOCB_CMD_VCI_DET: vci_valid_r <= 1'b1;
                     `EOCB_CMD_OPT_RD, `EOCB_CMD_UID_RD, `EOCB_CMD_STATUS_RD,
                     `EOCB_CMD_CRC_RD:
                        state_r <= ST_READ;
                     `EOCB_CMD_WS_PROG, `EOCB_CMD_WS_LOAD, `EOCB_CMD_SEL_PROG,
                     `EOCB_CMD_CRC_CALC:
                     begin
                        busy_r <= 1'b1;
                        tmr_r <= OP_CYCLES;
                        state_r <= ST_BUSY;
                        otp_op_r[0] <= (byte_in == `EOCB_CMD_WS_PROG);
                        otp_op_r[1] <= (byte_in == `EOCB_CMD_WS_LOAD);
                        otp_op_r[2] <= (byte_in == `EOCB_CMD_SEL_PROG);
                        otp_op_r[3] <= (byte_in == `EOCB_CMD_CRC_CALC);
                     end
                     default: ;
                  endcase
               end
               else if (state_r == ST_READ && sel && bit_r == 3'h0 && !fall && tx_r == 8'h00
                        && !sdout_oe_r)
                  tx_r <= rd_byte;
               else if (state_r == ST_READ && byte_done)
               begin
                  idx_r <= idx_r + 8'h01;
                  tx_r <= 8'h00;
                  sdout_oe_r <= 1'b0;
               end
               else if (state_r == ST_PARM && byte_done)
               begin
                  idx_r <= idx_r + 8'h01;
                  case (cmd_r)
                     `EOCB_CMD_COMMON_ELECTRODE_VOLTAGE_WR:
                        if (idx_r == 8'h00)
                        begin
                           common_electrode_voltage_r <= byte_in;
                           common_electrode_voltage_code_valid_r <= byte_in >= `EOCB_COMMON_ELECTRODE_VOLTAGE_MIN &&
                              byte_in <= `EOCB_COMMON_ELECTRODE_VOLTAGE_MAX && byte_in[1:0] == 2'h0;
                        end
                     `EOCB_CMD_UID_WR:
                        if (idx_r < 8'h0a) uid_mem[idx_r[3:0]] <= byte_in;
                     `EOCB_CMD_OPT_WR:
                        if (idx_r == 8'h00) spare_common_electrode_voltage_sel_r <= byte_in[7];
                        else if (idx_r < {4'h0, `EOCB_OPT_BYTES})
                        begin
                           opt_mem[idx_r[3:0] - 4'h1] <= byte_in;
                           if (idx_r == 8'h05) ram_alternation_r <= byte_in[6];
                        end
                     `EOCB_CMD_LUT_WR:
                        if (idx_r < `EOCB_LUT_BYTES)
                        begin
                           lut_wr_r <= 1'b1;
                           lut_addr_r <= idx_r;
                           lut_data_r <= byte_in;
                        end
                     `EOCB_CMD_PROG_MODE:
                        if (idx_r == 8'h00) prog_mode_r <= byte_in[1:0];
                     `EOCB_CMD_BORDER:
                        if (idx_r == 8'h00)
                        begin
                           border_sel_r <= byte_in[7:6];
                           border_level_r <= byte_in[5:4];
                           border_follow_r <= byte_in[2];
                           border_lut_r <= byte_in[1:0];
                        end
                     `EOCB_CMD_SEQ_CTRL:
                        if (idx_r == 8'h00)
                        begin
                           internal_clock_on_r <= byte_in[`EOCB_SEQ_CLK_BIT];
                           analog_supply_on_r <= byte_in[`EOCB_SEQ_CLK_BIT] &
                                                 byte_in[`EOCB_SEQ_ANA_BIT];
                        end
                     default: ;
                  endcase
               end
            ST_BUSY:
               if (tmr_r <= 32'h1)
               begin
                  busy_r <= 1'b0;
                  if (otp_op_r[3]) crc_r <= crc_value;
                  otp_op_r <= 5'h00;
                  state_r <= ST_IDLE;
               end
               else
                  tmr_r <= tmr_r - 32'h1;
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule // eocb_cmd

// >>> logic/eocb_map.vh
// Command codes, field positions, reset values and timing counts for the option command block
`ifndef EOCB_MAP_VH
`define EOCB_MAP_VH
`define EOCB_CMD_COMMON_ELECTRODE_VOLTAGE_WR     8'h2c
`define EOCB_CMD_OPT_RD      8'h2d
`define EOCB_CMD_UID_RD      8'h2e
`define EOCB_CMD_STATUS_RD   8'h2f
`define EOCB_CMD_WS_PROG     8'h30
`define EOCB_CMD_WS_LOAD     8'h31
`define EOCB_CMD_LUT_WR      8'h32
`define EOCB_CMD_CRC_CALC    8'h34
`define EOCB_CMD_CRC_RD      8'h35
`define EOCB_CMD_SEL_PROG    8'h36
`define EOCB_CMD_OPT_WR      8'h37
`define EOCB_CMD_UID_WR      8'h38
`define EOCB_CMD_PROG_MODE   8'h39
`define EOCB_CMD_BORDER      8'h3c
`define EOCB_CMD_HV_DET      8'h14
`define EOCB_CMD_VCI_DET     8'h15
`define EOCB_CMD_SEQ_CTRL    8'h22
`define EOCB_COMMON_ELECTRODE_VOLTAGE_MIN        8'h08
`define EOCB_COMMON_ELECTRODE_VOLTAGE_MAX        8'h78
`define EOCB_COMMON_ELECTRODE_VOLTAGE_RST        8'h00
`define EOCB_BORDER_RST      8'hc0
`define EOCB_SEQ_RST         8'hff
`define EOCB_MODE_RST        2'h0
`define EOCB_LUT_BYTES       8'h99
`define EOCB_OPT_BYTES       4'ha
`define EOCB_OPT_RD_BYTES    4'hb
`define EOCB_ST_HV_BIT       5
`define EOCB_ST_VCI_BIT      4
`define EOCB_ST_BUSY_BIT     2
`define EOCB_SEQ_CLK_BIT     7
`define EOCB_SEQ_ANA_BIT     6
`define EOCB_OP_TIME_US      100
`define EOCB_CLK_MHZ         10
`define EOCB_OP_CYCLES       (`EOCB_OP_TIME_US * `EOCB_CLK_MHZ)
`endif
